// [include/dac_cfg_defs.svh]
// Constants of the main configuration register bank.
// Assumes a 32-bit serial frame: access bit, 7-bit address, 24-bit data.
`ifndef DAC_CFG_DEFS_SVH
`define DAC_CFG_DEFS_SVH

// ==========================================================
// Frame layout
`define FRAME_CNT_W 5
`define FRAME_LAST 5'd31
`define FRM_RD_BIT 31
`define FRM_ADDR_HI 30
`define FRM_ADDR_LO 24
`define CFG_ADDR 7'h02

// ==========================================================
// Field positions of main_configuration
`define CFG_TEMP_CAL 23
`define CFG_MASK_HI 19
`define CFG_MASK_LO 18
`define CFG_UPD_MODE 14
`define CFG_FAST_SDO 13
`define CFG_ALM_EN 12
`define CFG_SDO_EN 11
`define CFG_SETTLE 10
`define CFG_SPAN_HI 9
`define CFG_SPAN_LO 6
`define CFG_PDN 4

// ==========================================================
// Reset value, writable bits, illegal spans
`define CFG_RESET 24'h004C80
`define CFG_RW_MASK 24'h8C7FD0
`define SPAN_BAD0 4'h0
`define SPAN_BAD1 4'h1

// ==========================================================
// Code-jump thresholds of the hold mask
`define THR_MASK_00 16'h4000
`define THR_MASK_01 16'h8000
`define THR_MASK_10 16'h2000
`define THR_MASK_11 16'h1000

`endif

// [include/dac_cfg_pkg.sv]
// Types of the configuration register bank.
// Assumes dac_cfg_defs.svh is on the include path.
package dac_cfg_pkg;

  // ==========================================================
  // System clock domain state
  typedef struct packed {
    logic frm_s1;
    logic frm_s2;
    logic frm_s3;
    logic ld_s1;
    logic ld_s2;
    logic ld_s3;
    logic dn_s1;
    logic dn_s2;
    logic dn_s3;
    logic [23:0] cfg;
    logic upd;
    logic alarm;
  } sys_state_t;

  // ==========================================================
  // Link clock domain state
  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic en_s1;
    logic en_s2;
    logic fast_s1;
    logic fast_s2;
    logic [4:0] cnt;
    logic [31:0] sh;
    logic [31:0] word;
    logic tgl;
    logic serial_data_out;
  } link_state_t;

endpackage : dac_cfg_pkg

// [hw/dac_cfg_link.sv]
// Serial link end of the configuration bank, clocked by the link clock.
// Assumes frame_n_i and serial_data_in_i change away from rising link edges.
`timescale 1ns/1ps
`include "dac_cfg_defs.svh"

module dac_cfg_link
  import dac_cfg_pkg::*;
(
  // Link clock and system reset
  input wire logic link_clk_i,
  input wire logic rst_n_i,
  // Link pins
  input wire logic frame_n_i,
  input wire logic serial_data_in_i,
  output logic serial_data_out_o,
  output logic serial_data_out_oe_o,
  // From the register bank
  input wire logic serial_out_enable_i,
  input wire logic fast_serial_out_enable_i,
  input wire logic [23:0] read_word_i,
  // To the register bank
  output logic [31:0] word_o,
  output logic word_tgl_o
);

  // ==========================================================
  // State
  link_state_t q;
  link_state_t d;
  logic [31:0] shifted;

  always_comb begin
    d = q;
    shifted = {q.sh[30:0], serial_data_in_i};
    d.rst_s1 = rst_n_i;
    d.rst_s2 = q.rst_s1;
    d.en_s1 = serial_out_enable_i;
    d.en_s2 = q.en_s1;
    d.fast_s1 = fast_serial_out_enable_i;
    d.fast_s2 = q.fast_s1;
    if (!q.rst_s2) begin
      d.cnt = '0;
      d.sh = '0;
      d.word = '0;
      d.tgl = 1'b0;
      d.serial_data_out = 1'b0;
    end else if (frame_n_i) begin
      d.cnt = '0;
    end else begin
      d.sh = shifted;
      d.serial_data_out = q.sh[31];
      d.cnt = q.cnt + 5'd1;
      if (q.cnt == `FRAME_LAST) begin
        // Word is held until the next full frame, so the bank reads it calmly
        d.word = shifted;
        d.tgl = ~q.tgl;
        // Read of the bank loads the answer for the next frame
        // The bank word only changes after a write frame, so it is quiet here
        if (shifted[`FRM_RD_BIT] && shifted[`FRM_ADDR_HI:`FRM_ADDR_LO] == `CFG_ADDR) begin
          d.sh = {1'b1, `CFG_ADDR, read_word_i};
        end
      end
    end
  end

  always_ff @(posedge link_clk_i) begin
    q <= d;
  end

  // ==========================================================
  // Outputs
  // Fast mode drops the retiming stage, giving one bit more of margin
  assign serial_data_out_o = q.fast_s2 ? q.sh[31] : q.serial_data_out;
  assign serial_data_out_oe_o = q.en_s2;
  assign word_o = q.word;
  assign word_tgl_o = q.tgl;

endmodule : dac_cfg_link

// [hw/dac_cfg_top.sv]
// Main configuration register bank of a voltage-output converter.
// Assumes the analog core runs on clk_sys_i and the link pins are direct.
`timescale 1ns/1ps
`include "dac_cfg_defs.svh"

module dac_cfg_top
  import dac_cfg_pkg::*;
(
  // System clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Serial link
  input wire logic link_clk_i,
  input wire logic frame_n_i,
  input wire logic serial_data_in_i,
  output logic serial_data_out_o,
  output logic serial_data_out_oe_o,
  // Update and alarm pins
  input wire logic load_strobe_n_i,
  output logic alarm_n_o,
  output logic alarm_n_oe_o,
  // Analog core inputs
  input wire logic track_hold_disable_i,
  input wire logic cal_done_i,
  // Analog core controls
  output logic dac_update_o,
  output logic [15:0] hold_mask_threshold_o,
  output logic update_mode_select_o,
  output logic fast_serial_out_enable_o,
  output logic alarm_pin_enable_o,
  output logic serial_out_enable_o,
  output logic settling_mode_select_o,
  output logic [3:0] reference_span_select_o,
  output logic converter_power_down_o,
  output logic temperature_cal_enable_o
);

  // ==========================================================
  // Helpers
  function automatic logic [15:0] mask_threshold(input logic [1:0] code);
    logic [15:0] thr;
    unique case (code)
      2'b00: thr = `THR_MASK_00;
      2'b01: thr = `THR_MASK_01;
      2'b10: thr = `THR_MASK_10;
      2'b11: thr = `THR_MASK_11;
    endcase
    return thr;
  endfunction : mask_threshold

  function automatic logic span_invalid(input logic [3:0] code);
    return (code == `SPAN_BAD0) || (code == `SPAN_BAD1);
  endfunction : span_invalid

  // ==========================================================
  // Serial link
  sys_state_t q;
  sys_state_t d;
  logic [31:0] link_word;
  logic link_tgl;

  dac_cfg_link u_link (
    .link_clk_i(link_clk_i),
    .rst_n_i(rst_n_i),
    .frame_n_i(frame_n_i),
    .serial_data_in_i(serial_data_in_i),
    .serial_data_out_o(serial_data_out_o),
    .serial_data_out_oe_o(serial_data_out_oe_o),
    .serial_out_enable_i(serial_out_enable_o),
    .fast_serial_out_enable_i(fast_serial_out_enable_o),
    .read_word_i(q.cfg),
    .word_o(link_word),
    .word_tgl_o(link_tgl)
  );

  // ==========================================================
  // State
  logic accept;
  logic accept_wr;
  logic frame_rise;
  logic load_fall;
  logic mask_locked;
  logic [23:0] wr;

  assign accept = q.dn_s2 ^ q.dn_s3;
  assign accept_wr = accept && !link_word[`FRM_RD_BIT]
    && link_word[`FRM_ADDR_HI:`FRM_ADDR_LO] == `CFG_ADDR;
  assign frame_rise = q.frm_s2 && !q.frm_s3;
  assign load_fall = !q.ld_s2 && q.ld_s3;
  // Lock is judged on the settling bit held before this frame
  assign mask_locked = q.cfg[`CFG_SETTLE] || track_hold_disable_i;

  always_comb begin
    d = q;
    wr = link_word[23:0] & `CFG_RW_MASK;
    d.frm_s1 = frame_n_i;
    d.frm_s2 = q.frm_s1;
    d.frm_s3 = q.frm_s2;
    d.ld_s1 = load_strobe_n_i;
    d.ld_s2 = q.ld_s1;
    d.ld_s3 = q.ld_s2;
    d.dn_s1 = link_tgl;
    d.dn_s2 = q.dn_s1;
    d.dn_s3 = q.dn_s2;
    // Update strobe: frame end in synchronous mode, load pin otherwise
    d.upd = 1'b0;
    if (!q.cfg[`CFG_UPD_MODE] && frame_rise) begin
      d.upd = 1'b1;
    end
    if (q.cfg[`CFG_UPD_MODE] && load_fall) begin
      d.upd = 1'b1;
    end
    // Field writes take effect only once the whole frame has arrived
    if (accept_wr) begin
      if (mask_locked) begin
        wr[`CFG_MASK_HI:`CFG_MASK_LO] = q.cfg[`CFG_MASK_HI:`CFG_MASK_LO];
      end
      // An illegal span would leave the core unreferenced, so keep the old one
      if (span_invalid(wr[`CFG_SPAN_HI:`CFG_SPAN_LO])) begin
        wr[`CFG_SPAN_HI:`CFG_SPAN_LO] = q.cfg[`CFG_SPAN_HI:`CFG_SPAN_LO];
      end
      d.cfg = wr;
    end
    // Alarm: any accepted frame or a disabled pin clears, calibration end sets
    if (accept || !q.cfg[`CFG_ALM_EN]) begin
      d.alarm = 1'b0;
    end
    if (cal_done_i && q.cfg[`CFG_ALM_EN]) begin
      d.alarm = 1'b1;
    end
    if (!rst_n_i) begin
      d.cfg = `CFG_RESET;
      d.upd = 1'b0;
      d.alarm = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    q <= d;
  end

  // ==========================================================
  // Outputs
  assign dac_update_o = q.upd;
  assign hold_mask_threshold_o = mask_threshold(q.cfg[`CFG_MASK_HI:`CFG_MASK_LO]);
  assign update_mode_select_o = q.cfg[`CFG_UPD_MODE];
  assign fast_serial_out_enable_o = q.cfg[`CFG_FAST_SDO];
  assign alarm_pin_enable_o = q.cfg[`CFG_ALM_EN];
  assign serial_out_enable_o = q.cfg[`CFG_SDO_EN];
  assign settling_mode_select_o = q.cfg[`CFG_SETTLE];
  assign reference_span_select_o = q.cfg[`CFG_SPAN_HI:`CFG_SPAN_LO];
  assign converter_power_down_o = q.cfg[`CFG_PDN];
  assign temperature_cal_enable_o = q.cfg[`CFG_TEMP_CAL];
  // Open-drain alarm: drive low only while active
  assign alarm_n_o = 1'b0;
  assign alarm_n_oe_o = q.alarm;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  property p_mask_locked;
    accept_wr && mask_locked |=> $stable(hold_mask_threshold_o);
  endproperty
  a_mask_locked: assert property (p_mask_locked)
    else $error("hold mask changed while locked");

  property p_mask_open;
    accept_wr && !mask_locked |=>
      q.cfg[`CFG_MASK_HI:`CFG_MASK_LO] == $past(link_word[`CFG_MASK_HI:`CFG_MASK_LO]);
  endproperty
  a_mask_open: assert property (p_mask_open)
    else $error("hold mask write lost");

  property p_threshold;
    q.cfg[`CFG_MASK_HI:`CFG_MASK_LO] == 2'b10 |-> hold_mask_threshold_o == 16'h2000;
  endproperty
  a_threshold: assert property (p_threshold)
    else $error("wrong code-jump threshold");

  property p_update_sync;
    frame_rise && !update_mode_select_o |=> dac_update_o ##1 !dac_update_o;
  endproperty
  a_update_sync: assert property (p_update_sync)
    else $error("no single update on frame rise");

  property p_update_quiet;
    !(frame_rise && !update_mode_select_o) && !(load_fall && update_mode_select_o)
      |=> !dac_update_o;
  endproperty
  a_update_quiet: assert property (p_update_quiet)
    else $error("spurious update strobe");

  property p_alarm_set;
    cal_done_i && alarm_pin_enable_o |=> alarm_n_oe_o && !alarm_n_o;
  endproperty
  a_alarm_set: assert property (p_alarm_set)
    else $error("alarm not raised after calibration");

  property p_alarm_off;
    !alarm_pin_enable_o |=> !alarm_n_oe_o;
  endproperty
  a_alarm_off: assert property (p_alarm_off)
    else $error("alarm driven while disabled");

  property p_span_legal;
    !span_invalid(reference_span_select_o);
  endproperty
  a_span_legal: assert property (p_span_legal)
    else $error("illegal reference span held");

  property p_write_fields;
    accept_wr |=> converter_power_down_o == $past(link_word[`CFG_PDN])
      && settling_mode_select_o == $past(link_word[`CFG_SETTLE])
      && temperature_cal_enable_o == $past(link_word[`CFG_TEMP_CAL]);
  endproperty
  a_write_fields: assert property (p_write_fields)
    else $error("write frame not applied");

  property p_reserved_zero;
    (q.cfg & ~`CFG_RW_MASK) == 24'h000000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bit set");

  property p_reset_value;
    $rose(rst_n_i) |-> q.cfg == 24'h004C80;
  endproperty
  a_reset_value: assert property (p_reset_value)
    else $error("wrong reset value");

  property p_read_no_write;
    accept && link_word[`FRM_RD_BIT] |=> $stable(q.cfg);
  endproperty
  a_read_no_write: assert property (p_read_no_write)
    else $error("read frame changed the register");

  property p_threshold_00;
    q.cfg[`CFG_MASK_HI:`CFG_MASK_LO] == 2'h0 |-> hold_mask_threshold_o == 16'h4000;
  endproperty
  a_threshold_00: assert property (p_threshold_00)
    else $error("wrong default code-jump threshold");

  property p_threshold_01;
    q.cfg[`CFG_MASK_HI:`CFG_MASK_LO] == 2'h1 |-> hold_mask_threshold_o == 16'h8000;
  endproperty
  a_threshold_01: assert property (p_threshold_01)
    else $error("wrong widest code-jump threshold");

  property p_threshold_11;
    q.cfg[`CFG_MASK_HI:`CFG_MASK_LO] == 2'h3 |-> hold_mask_threshold_o == 16'h1000;
  endproperty
  a_threshold_11: assert property (p_threshold_11)
    else $error("wrong narrowest code-jump threshold");

  property p_update_async;
    load_fall && update_mode_select_o |=> dac_update_o ##1 !dac_update_o;
  endproperty
  a_update_async: assert property (p_update_async)
    else $error("no single update on load fall");

  // Set wins over the frame clear, so a calibration end is never lost
  property p_alarm_clear;
    accept && !(cal_done_i && alarm_pin_enable_o) |=> !alarm_n_oe_o;
  endproperty
  a_alarm_clear: assert property (p_alarm_clear)
    else $error("alarm not cleared by frame");

  property p_alarm_hold;
    alarm_n_oe_o && alarm_pin_enable_o && !accept |=> alarm_n_oe_o;
  endproperty
  a_alarm_hold: assert property (p_alarm_hold)
    else $error("alarm dropped on its own");

  // A cut frame never toggles, so it leaves the fields as they were
  property p_cfg_quiet;
    !accept_wr |=> $stable(q.cfg);
  endproperty
  a_cfg_quiet: assert property (p_cfg_quiet)
    else $error("register changed without a write frame");

  property p_write_modes;
    accept_wr |=> update_mode_select_o == $past(link_word[`CFG_UPD_MODE])
      && fast_serial_out_enable_o == $past(link_word[`CFG_FAST_SDO])
      && alarm_pin_enable_o == $past(link_word[`CFG_ALM_EN])
      && serial_out_enable_o == $past(link_word[`CFG_SDO_EN]);
  endproperty
  a_write_modes: assert property (p_write_modes)
    else $error("mode bits of write frame not applied");

  property p_span_write;
    accept_wr && !span_invalid(link_word[`CFG_SPAN_HI:`CFG_SPAN_LO]) |=>
      reference_span_select_o == $past(link_word[`CFG_SPAN_HI:`CFG_SPAN_LO]);
  endproperty
  a_span_write: assert property (p_span_write)
    else $error("legal span not applied");

  property p_span_keep;
    accept_wr && span_invalid(link_word[`CFG_SPAN_HI:`CFG_SPAN_LO]) |=>
      $stable(reference_span_select_o);
  endproperty
  a_span_keep: assert property (p_span_keep)
    else $error("illegal span replaced the old one");

  property p_addr_other;
    accept && link_word[`FRM_ADDR_HI:`FRM_ADDR_LO] != `CFG_ADDR |=> $stable(q.cfg);
  endproperty
  a_addr_other: assert property (p_addr_other)
    else $error("frame to another address changed the register");

  property p_reset_fields;
    $rose(rst_n_i) |-> update_mode_select_o && serial_out_enable_o && settling_mode_select_o
      && reference_span_select_o == 4'h2 && !converter_power_down_o
      && !fast_serial_out_enable_o && !alarm_pin_enable_o && !temperature_cal_enable_o
      && hold_mask_threshold_o == 16'h4000 && !dac_update_o && !alarm_n_oe_o;
  endproperty
  a_reset_fields: assert property (p_reset_fields)
    else $error("wrong field values after reset");

endmodule : dac_cfg_top

// [test/host_model.sv]
// Host model: drives frames on the serial link of the configuration bank.
// Assumes the bench resolves the serial output line and feeds it to so_i.
`timescale 1ns/1ps
module host_model (
  // Link pins
  output logic sclk_o,
  output logic frame_n_o,
  output logic sdi_o,
  input wire logic so_i
);
  initial begin
    sclk_o = 1'b0;
    frame_n_o = 1'b1;
    sdi_o = 1'b0;
  end

  // ==========================================================
  // Idle edges, only so the link side can leave reset
  task automatic idle(input int n);
    repeat (n) begin
      #6 sclk_o = 1'b1;
      #6 sclk_o = 1'b0;
    end
  endtask : idle

  // ==========================================================
  // One frame, MSB first; 33 samples of the reply, one before each rising edge and one after the last
  task automatic xfer(input logic [31:0] w, output logic [32:0] r);
    frame_n_o = 1'b0;
    r = '0;
    for (int i = 31; i >= 0; i--) begin
      sdi_o = w[i];
      r = {r[31:0], so_i};
      #6 sclk_o = 1'b1;
      #6 sclk_o = 1'b0;
    end
    r = {r[31:0], so_i};
    #6 frame_n_o = 1'b1;
    // Clock stands still; data line no longer shows the last bit
    sdi_o = ~w[0];
    #24;
  endtask : xfer
endmodule : host_model

// [test/tb_top.sv]
// Bench: configuration frames through the host model, pin events by the bench.
// Assumes host_model and the design files are compiled first.
`timescale 1ns/1ps
module tb_top;
  logic clk_sys_i, rst_n_i, ld_n, thd, cal;
  logic sclk, frm_n, sdi, so, so_oe, alm_n, alm_oe, upd;
  logic tcal, umode, fast_serial_out_enable, alen, soen, st, converter_power_down;
  logic [15:0] thr_o;
  logic [3:0] span;
  logic [23:0] e;
  logic [32:0] r;
  int bad_count = 0;
  int compares = 0;
  int ucnt = 0;
  int cyc = 0;
  int u0;
  tri1 so_w;
  wire [26:0] outv = {tcal, thr_o, umode, fast_serial_out_enable, alen, soen, st, span, converter_power_down};
  assign so_w = so_oe ? so : 1'bz;

  dac_cfg_top dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .link_clk_i(sclk),
    .frame_n_i(frm_n), .serial_data_in_i(sdi), .serial_data_out_o(so),
    .serial_data_out_oe_o(so_oe), .load_strobe_n_i(ld_n), .alarm_n_o(alm_n),
    .alarm_n_oe_o(alm_oe), .track_hold_disable_i(thd), .cal_done_i(cal),
    .dac_update_o(upd), .hold_mask_threshold_o(thr_o), .update_mode_select_o(umode),
    .fast_serial_out_enable_o(fast_serial_out_enable), .alarm_pin_enable_o(alen),
    .serial_out_enable_o(soen), .settling_mode_select_o(st),
    .reference_span_select_o(span), .converter_power_down_o(converter_power_down),
    .temperature_cal_enable_o(tcal));
  host_model host (.sclk_o(sclk), .frame_n_o(frm_n), .sdi_o(sdi), .so_i(so_w));

  // ==========================================================
  // Clock, update counter, timeout
  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (upd === 1'b1) ucnt <= ucnt + 1;
    if (cyc == 20000) begin
      bad_count++;
      summarize();
    end
  end

  // ==========================================================
  // Helpers
  task automatic chk(input string n, input logic [32:0] x, input logic [32:0] g);
    compares++;
    if (g !== x) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, x, g);
    end
  endtask : chk

  function automatic logic [15:0] thr(logic [1:0] m);
    case (m)
      2'h0: return 16'h4000;
      2'h1: return 16'h8000;
      2'h2: return 16'h2000;
      default: return 16'h1000;
    endcase
  endfunction : thr

  function automatic logic [26:0] expv(logic [23:0] v);
    return {v[23], thr(v[19:18]), v[14:10], v[9:6], v[4]};
  endfunction : expv

  // Mask judged on the value before the frame; bad spans keep the old span
  function automatic logic [23:0] nxt(logic [23:0] o, logic [23:0] d);
    logic [23:0] n;
    n = d & 24'h8C7FD0;
    if (o[10] || thd) n[19:18] = o[19:18];
    if (d[9:6] < 4'h2) n[9:6] = o[9:6];
    return n;
  endfunction : nxt

  task automatic wr(input logic [23:0] d);
    host.xfer({8'h02, d}, r);
    e = nxt(e, d);
    repeat (8) @(negedge clk_sys_i);
    chk("outputs", 33'(expv(e)), 33'(outv));
  endtask : wr

  // Reply comes in the following frame; a disabled output floats high
  task automatic rd();
    logic [31:0] x;
    logic [31:0] g;
    host.xfer(32'h82000000, r);
    host.xfer(32'h82000000, r);
    x = e[11] ? {8'h82, e} : 32'hFFFFFFFF;
    g = e[13] ? r[32:1] : r[31:0];
    chk("readback", 33'(x), 33'(g));
    chk("so_oe", 33'(e[11]), 33'(so_oe));
  endtask : rd

  task automatic pulse_ld();
    @(negedge clk_sys_i) ld_n = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    ld_n = 1'b1;
  endtask : pulse_ld

  task automatic pulse_cal();
    @(negedge clk_sys_i) cal = 1'b1;
    @(negedge clk_sys_i) cal = 1'b0;
  endtask : pulse_cal

  task automatic summarize();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize

  // ==========================================================
  // Tests
  initial begin
    rst_n_i = 1'b0;
    ld_n = 1'b1;
    thd = 1'b0;
    cal = 1'b0;
    e = 24'h004C80;
    fork host.idle(4); join_none
    repeat (12) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    host.idle(4);
    chk("outputs", 33'(expv(e)), 33'(outv));
    chk("alarm_oe", 33'(0), 33'(alm_oe));
    rd();
    $display("test reset done");
    wr(24'hFFFFFF);
    rd();
    for (int i = 0; i < 5; i++) wr(24'h004880 | (24'((i + 3) % 4) << 18));
    @(negedge clk_sys_i) thd = 1'b1;
    wr(24'h004880);
    @(negedge clk_sys_i) thd = 1'b0;
    rd();
    $display("test hold mask done");
    for (int s = 0; s < 16; s++) wr(24'h004800 | (24'(s) << 6));
    host.xfer(32'h03000000, r);
    rd();
    $display("test span and address done");
    u0 = ucnt;
    pulse_ld();
    host.xfer(32'h03000000, r);
    repeat (6) @(negedge clk_sys_i);
    chk("updates", 33'(u0 + 1), 33'(ucnt));
    wr(24'h000880);
    u0 = ucnt;
    pulse_ld();
    host.xfer(32'h03000000, r);
    repeat (6) @(negedge clk_sys_i);
    chk("updates", 33'(u0 + 1), 33'(ucnt));
    $display("test update mode done");
    wr(24'h005880);
    pulse_cal();
    chk("alarm_oe", 33'(1), 33'(alm_oe));
    chk("alarm_n", 33'(0), 33'(alm_n));
    wr(24'h004880);
    pulse_cal();
    chk("alarm_oe", 33'(0), 33'(alm_oe));
    $display("test alarm done");
    wr(24'h004080);
    rd();
    $display("test serial out done");
    summarize();
  end
endmodule : tb_top
